// *** src/lcdseg_pkg.sv ***
// Purpose: Shared constants and types for the segment LCD control registers.
// Assumes: AHB-Lite slave, 32-bit data, one register per aligned word.
// Notes: Register offsets are byte addresses in the low address bits.
package lcdseg_pkg;
   // ==========================================================
   // Geometry
   localparam int LCDSEG_FP_COUNT = 41;
   localparam int LCDSEG_BP_COUNT = 4;
   localparam int LCDSEG_SEG_BYTES = 21;
   localparam int LCDSEG_FPEN_REGS = 6;
   localparam int LCDSEG_ADDR_W = 8;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] OFS_CTRL0 = 8'h00;
   localparam logic [7:0] OFS_CTRL1 = 8'h04;
   localparam logic [7:0] OFS_FPEN0 = 8'h08;
   localparam logic [7:0] OFS_CMD = 8'h20;
   localparam logic [7:0] OFS_SEG0 = 8'h40;

   // ==========================================================
   // Field positions
   localparam int CTRL0_DRV_EN_BIT = 7;
   localparam int CTRL0_LOW_POWER_WAVEFORM_SELECT_BIT = 6;
   localparam int CTRL1_IRQ_EN_BIT = 7;
   localparam int CTRL1_WAIT_STOP_BIT = 1;
   localparam int CTRL1_STOP3_STOP_BIT = 0;
   localparam int CMD_BANK_SEL_BIT = 0;

   // ==========================================================
   // Reset values and write masks
   localparam logic [7:0] CTRL0_RST = 8'h00;
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [7:0] FPEN_RST = 8'h00;
   localparam logic [7:0] CMD_RST = 8'h00;
   localparam logic [7:0] CTRL1_MASK = 8'h83;
   localparam logic [7:0] CMD_MASK = 8'h01;
   localparam logic [7:0] FPEN_LAST_MASK = 8'h01;
   localparam logic [7:0] SEG_LAST_MASK = 8'h0f;

   // ==========================================================
   // Bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic HRESP_OKAY = 1'b0;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      LCDSEG_PH_IDLE = 2'b00,
      LCDSEG_PH_WRITE = 2'b01,
      LCDSEG_PH_READ = 2'b10
   } lcdseg_phase_t;

   typedef struct packed {
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
   } lcdseg_ahb_addr_t;

   typedef struct packed {
      logic waitMode;
      logic stop3Mode;
   } lcdseg_pm_t;

   typedef struct packed {
      logic frameStart;
      logic subFrameStart;
   } lcdseg_frame_t;
endpackage

// *** src/lcdseg_control_regs.sv ***
// Purpose: Register bank of a segment LCD driver behind an AHB-Lite slave.
// Assumes: Inputs synchronous to clk; one slave, hready is our hreadyout.
// Notes: Reads take one wait state, writes none; segment memory has no reset.
`timescale 1ns/1ps

module lcdseg_control_regs #(
   parameter int FP_COUNT = lcdseg_pkg::LCDSEG_FP_COUNT,
   parameter int BP_COUNT = lcdseg_pkg::LCDSEG_BP_COUNT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire lcdseg_pkg::lcdseg_ahb_addr_t ahbAddr,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Processor power modes and frame timing
   input wire lcdseg_pkg::lcdseg_pm_t powerMode,
   input wire lcdseg_pkg::lcdseg_frame_t frameEvents,
   // Driver controls and interrupt
   output logic frameIrq,
   output logic waveClockRun,
   output logic chargePumpRun,
   output logic lowPowerWaveSelect,
   output logic [FP_COUNT-1:0] frontplaneOutEn,
   output logic [BP_COUNT-1:0] backplaneOutEn,
   // Segment state to the waveform generator
   output logic [FP_COUNT*BP_COUNT-1:0] segmentOn,
   output logic [FP_COUNT*BP_COUNT-1:0] segmentBlink
);
   import lcdseg_pkg::*;

   localparam int SEG_BYTES = (FP_COUNT + 1) / 2;
   localparam int FPEN_REGS = (FP_COUNT + 7) / 8;

   // ==========================================================
   // Elaboration checks
   if (FP_COUNT != LCDSEG_FP_COUNT || BP_COUNT != LCDSEG_BP_COUNT) begin : g_bad_geometry
      $error("Register map is fixed to 41 frontplanes and 4 backplanes");
   end

   // ==========================================================
   // Storage
   logic [7:0] ctrl0;
   logic [7:0] ctrl1;
   logic [7:0] command;
   logic [7:0] fpEnableReg [FPEN_REGS];
   logic [7:0] onMem [SEG_BYTES];
   logic [7:0] blinkMem [SEG_BYTES];
   logic [FP_COUNT-1:0] fpEnable;

   // ==========================================================
   // Bus phase tracking
   lcdseg_phase_t phase;
   logic [LCDSEG_ADDR_W-1:0] dataAddr;
   logic addrTaken;
   logic wrDo;
   logic rdDo;

   // Address phase accepted only on a selected NONSEQ with the bus ready
   assign addrTaken = hsel && hready && (ahbAddr.htrans == HTRANS_NONSEQ);
   assign wrDo = (phase == LCDSEG_PH_WRITE);
   assign rdDo = (phase == LCDSEG_PH_READ);

   // Segment word decode, shared by write and read paths
   function automatic logic segHit(input logic [LCDSEG_ADDR_W-1:0] a);
      segHit = (a >= OFS_SEG0) && (a < OFS_SEG0 + 8'(4 * SEG_BYTES)) && (a[1:0] == 2'b00);
   endfunction

   function automatic logic [4:0] segIndex(input logic [LCDSEG_ADDR_W-1:0] a);
      logic [LCDSEG_ADDR_W-1:0] off;
      off = a - OFS_SEG0;
      segIndex = off[6:2];
   endfunction

   function automatic logic fpenHit(input logic [LCDSEG_ADDR_W-1:0] a);
      fpenHit = (a >= OFS_FPEN0) && (a < OFS_FPEN0 + 8'(4 * FPEN_REGS)) && (a[1:0] == 2'b00);
   endfunction

   function automatic logic [2:0] fpenIndex(input logic [LCDSEG_ADDR_W-1:0] a);
      logic [LCDSEG_ADDR_W-1:0] off;
      off = a - OFS_FPEN0;
      fpenIndex = off[4:2];
   endfunction

   // Phase register: a read holds the bus for one extra cycle
   always_ff @(posedge clk) begin
      if (!rstn) begin
         phase <= LCDSEG_PH_IDLE;
         dataAddr <= '0;
      end else if (addrTaken) begin
         phase <= ahbAddr.hwrite ? LCDSEG_PH_WRITE : LCDSEG_PH_READ;
         dataAddr <= ahbAddr.haddr[LCDSEG_ADDR_W-1:0];
      end else begin
         phase <= LCDSEG_PH_IDLE;
      end
   end

   // Wait state for reads so read data sees every earlier write
   always_ff @(posedge clk) begin
      if (!rstn) begin
         hreadyout <= 1'b1;
      end else begin
         hreadyout <= !(addrTaken && !ahbAddr.hwrite);
      end
   end

   // Slave only ever answers OKAY
   always_ff @(posedge clk) begin
      if (!rstn) begin
         hresp <= HRESP_OKAY;
      end else begin
         hresp <= HRESP_OKAY;
      end
   end

   // ==========================================================
   // Control registers
   // unimplemented ctrl bits
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ctrl0 <= CTRL0_RST;
         ctrl1 <= CTRL1_RST;
         command <= CMD_RST;
      end else if (wrDo) begin
         if (dataAddr == OFS_CTRL0) begin
            ctrl0 <= hwdata[7:0];
         end
         if (dataAddr == OFS_CTRL1) begin
            ctrl1 <= hwdata[7:0] & CTRL1_MASK;
         end
         if (dataAddr == OFS_CMD) begin
            command <= hwdata[7:0] & CMD_MASK;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         for (int i = 0; i < FPEN_REGS; i++) begin
            fpEnableReg[i] <= FPEN_RST;
         end
      end else if (wrDo && fpenHit(dataAddr)) begin
         // last register keeps bit 0 only
         if (fpenIndex(dataAddr) == 3'(FPEN_REGS - 1)) begin
            fpEnableReg[fpenIndex(dataAddr)] <= hwdata[7:0] & FPEN_LAST_MASK;
         end else begin
            fpEnableReg[fpenIndex(dataAddr)] <= hwdata[7:0];
         end
      end
   end

   generate
      for (genvar f = 0; f < FP_COUNT; f++) begin : g_fpen
         assign fpEnable[f] = fpEnableReg[f / 8][f % 8];
      end
   endgenerate

   // ==========================================================
   // Segment memory, two banks, deliberately without reset
   // no reset on memory
   always_ff @(posedge clk) begin
      if (wrDo && segHit(dataAddr)) begin
         if (command[CMD_BANK_SEL_BIT]) begin
            if (segIndex(dataAddr) == 5'(SEG_BYTES - 1)) begin
               blinkMem[segIndex(dataAddr)] <= hwdata[7:0] & SEG_LAST_MASK;
            end else begin
               blinkMem[segIndex(dataAddr)] <= hwdata[7:0];
            end
         end else begin
            if (segIndex(dataAddr) == 5'(SEG_BYTES - 1)) begin
               onMem[segIndex(dataAddr)] <= hwdata[7:0] & SEG_LAST_MASK;
            end else begin
               onMem[segIndex(dataAddr)] <= hwdata[7:0];
            end
         end
      end
   end

   // ==========================================================
   // Read data, registered in the wait state
   always_ff @(posedge clk) begin
      if (!rstn) begin
         hrdata <= '0;
      end else if (rdDo) begin
         hrdata <= '0;
         if (dataAddr == OFS_CTRL0) begin
            hrdata[7:0] <= ctrl0;
         end
         if (dataAddr == OFS_CTRL1) begin
            hrdata[7:0] <= ctrl1;
         end
         if (dataAddr == OFS_CMD) begin
            hrdata[7:0] <= command;
         end
         if (fpenHit(dataAddr)) begin
            hrdata[7:0] <= fpEnableReg[fpenIndex(dataAddr)];
         end
         if (segHit(dataAddr)) begin
            hrdata[7:0] <= command[CMD_BANK_SEL_BIT] ? blinkMem[segIndex(dataAddr)]
                                                      : onMem[segIndex(dataAddr)];
         end
      end
   end

   // ==========================================================
   // Driver run state and pin enables
   logic driverRun;

   assign driverRun = ctrl0[CTRL0_DRV_EN_BIT]
      && !(ctrl1[CTRL1_WAIT_STOP_BIT] && powerMode.waitMode)
      && !(ctrl1[CTRL1_STOP3_STOP_BIT] && powerMode.stop3Mode);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         waveClockRun <= 1'b0;
         chargePumpRun <= 1'b0;
         lowPowerWaveSelect <= 1'b0;
      end else begin
         waveClockRun <= driverRun;
         chargePumpRun <= driverRun;
         lowPowerWaveSelect <= ctrl0[CTRL0_LOW_POWER_WAVEFORM_SELECT_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         frontplaneOutEn <= '0;
         backplaneOutEn <= '0;
      end else begin
         frontplaneOutEn <= driverRun ? fpEnable : '0;
         backplaneOutEn <= driverRun ? '1 : '0;
      end
   end

   // ==========================================================
   // Frame interrupt request, one cycle per frame or sub-frame
   // request on frame start, or on sub-frame start with the low-power waveform
   always_ff @(posedge clk) begin
      if (!rstn) begin
         frameIrq <= 1'b0;
      end else begin
         frameIrq <= ctrl1[CTRL1_IRQ_EN_BIT] && driverRun
            && (ctrl0[CTRL0_LOW_POWER_WAVEFORM_SELECT_BIT] ? frameEvents.subFrameStart
                                        : frameEvents.frameStart);
      end
   end

   // ==========================================================
   // Segment state outputs
   // nibble per frontplane
   generate
      for (genvar k = 0; k < SEG_BYTES - 1; k++) begin : g_seg
         assign segmentOn[8*k +: 8] = onMem[k];
      end
   endgenerate
   assign segmentOn[8*(SEG_BYTES-1) +: 4] = onMem[SEG_BYTES-1][3:0];

   always_ff @(posedge clk) begin
      for (int k = 0; k < SEG_BYTES - 1; k++) begin
         segmentBlink[8*k +: 8] <= blinkMem[k] & onMem[k];
      end
      segmentBlink[8*(SEG_BYTES-1) +: 4] <= blinkMem[SEG_BYTES-1][3:0] & onMem[SEG_BYTES-1][3:0];
   end

   // ==========================================================
   // Assertions
   logic lastFrameEvt;
   assign lastFrameEvt = ctrl0[CTRL0_LOW_POWER_WAVEFORM_SELECT_BIT] ? frameEvents.subFrameStart
                                                 : frameEvents.frameStart;

   property p_irq_on_frame;
      @(posedge clk) disable iff (!rstn)
         (ctrl1[CTRL1_IRQ_EN_BIT] && driverRun && lastFrameEvt) |=> frameIrq;
   endproperty
   a_irq_on_frame: assert property (p_irq_on_frame) else $error("Frame interrupt missed");

   property p_irq_disabled;
      @(posedge clk) disable iff (!rstn)
         !ctrl1[CTRL1_IRQ_EN_BIT] |=> !frameIrq;
   endproperty
   a_irq_disabled: assert property (p_irq_disabled) else $error("Interrupt while disabled");

   property p_wait_stop;
      @(posedge clk) disable iff (!rstn)
         (ctrl1[CTRL1_WAIT_STOP_BIT] && powerMode.waitMode) |=> !waveClockRun && !chargePumpRun;
   endproperty
   a_wait_stop: assert property (p_wait_stop) else $error("Driver ran in wait");

   property p_stop3_stop;
      @(posedge clk) disable iff (!rstn)
         (ctrl1[CTRL1_STOP3_STOP_BIT] && powerMode.stop3Mode) |=> !waveClockRun
            && frontplaneOutEn == '0;
   endproperty
   a_stop3_stop: assert property (p_stop3_stop) else $error("Driver ran in stop3");

   property p_fp_follow;
      @(posedge clk) disable iff (!rstn)
         driverRun |=> frontplaneOutEn == $past(fpEnable);
   endproperty
   a_fp_follow: assert property (p_fp_follow) else $error("Frontplane enable mismatch");

   property p_fp_ignored;
      @(posedge clk) disable iff (!rstn)
         !ctrl0[CTRL0_DRV_EN_BIT] |=> frontplaneOutEn == '0 && backplaneOutEn == '0;
   endproperty
   a_fp_ignored: assert property (p_fp_ignored) else $error("Pins driven while off");

   property p_fp_last_bits;
      @(posedge clk) disable iff (!rstn)
         fpEnableReg[FPEN_REGS-1][7:1] == 7'h00;
   endproperty
   a_fp_last_bits: assert property (p_fp_last_bits) else $error("Reserved enable bits set");

   property p_read_wait;
      @(posedge clk) disable iff (!rstn)
         (addrTaken && !ahbAddr.hwrite) |=> !hreadyout ##1 hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("Read wait state wrong");

   property p_ctrl1_write;
      @(posedge clk) disable iff (!rstn)
         (wrDo && dataAddr == OFS_CTRL1) |=> ctrl1 == ($past(hwdata[7:0]) & CTRL1_MASK);
   endproperty
   a_ctrl1_write: assert property (p_ctrl1_write) else $error("Control write lost");

endmodule

// *** testbench/lcdseg_glass_model.sv ***
// Purpose: Passive model of the segment glass as seen through its drive pins.
// Assumes: A segment shows only while both of its electrodes are driven.
// Notes: Blink is reported as a flag; blink timing is not modelled.
`timescale 1ns/1ps
module lcdseg_glass_model #(
   parameter int FP_COUNT = 41,
   parameter int BP_COUNT = 4
) (
   // Electrode drive
   input wire logic [FP_COUNT-1:0] frontplaneOutEn,
   input wire logic [BP_COUNT-1:0] backplaneOutEn,
   // Segment state
   input wire logic [FP_COUNT*BP_COUNT-1:0] segmentOn,
   input wire logic [FP_COUNT*BP_COUNT-1:0] segmentBlink,
   // What a viewer sees
   output logic [FP_COUNT*BP_COUNT-1:0] segVisible,
   output logic [FP_COUNT*BP_COUNT-1:0] segFlashing
);
   // ==========================================================
   // Segment visibility
   // lit needs drive
   always_comb begin
      for (int i = 0; i < FP_COUNT * BP_COUNT; i++) begin
         segVisible[i] = segmentOn[i] & frontplaneOutEn[i/BP_COUNT] & backplaneOutEn[i%BP_COUNT];
         segFlashing[i] = segVisible[i] & segmentBlink[i];
      end
   end
endmodule

// *** testbench/lcd_segment_control_regs_tb_top.sv ***
// Purpose: Self-checking bench for the segment LCD control registers.
// Assumes: One AHB-Lite master; hready is the slave's hreadyout.
// Notes: Ready and read data are taken mid-cycle, as they only move on edges.
`timescale 1ns/1ps
module lcd_segment_control_regs_tb_top;
   import lcdseg_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic hsel = 1'b0;
   lcdseg_ahb_addr_t ahbAddr = '0;
   logic [31:0] hwdata = '0;
   logic hreadyout, hresp, frameIrq, waveClockRun, chargePumpRun, lowPowerWaveSelect, run;
   logic [31:0] hrdata, rd;
   lcdseg_pm_t powerMode = '0;
   lcdseg_frame_t frameEvents = '0;
   logic [40:0] fpEn;
   logic [3:0] bpEn;
   logic [163:0] segOn, segBlink, segVis, segFl;
   logic [7:0] rv;
   logic [167:0] eOn, eBl, eVis;
   logic [7:0] fe [6];
   logic [7:0] onB [21];
   logic [7:0] blB [21];
   int fails = 0;
   int tests_run = 0;

   // ==========================================================
   // Design and glass
   lcdseg_control_regs u_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .ahbAddr(ahbAddr),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .powerMode(powerMode), .frameEvents(frameEvents), .frameIrq(frameIrq),
      .waveClockRun(waveClockRun), .chargePumpRun(chargePumpRun),
      .lowPowerWaveSelect(lowPowerWaveSelect), .frontplaneOutEn(fpEn),
      .backplaneOutEn(bpEn), .segmentOn(segOn), .segmentBlink(segBlink));
   lcdseg_glass_model u_glass (.frontplaneOutEn(fpEn), .backplaneOutEn(bpEn),
      .segmentOn(segOn), .segmentBlink(segBlink), .segVisible(segVis), .segFlashing(segFl));

   // Free-running bus clock
   always #25 clk = ~clk;

   // ==========================================================
   // Checking and closing
   task automatic chk(input string nm, input logic [167:0] seen, input logic [167:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("Checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ==========================================================
   // Bus master
   // Bounded wait for hready at an edge; a hung slave ends the run
   task automatic wait_rdy(output logic [31:0] d);
      logic r;
      int n;
      n = 0;
      do begin
         @(negedge clk);
         r = hreadyout;
         d = hrdata;
         @(posedge clk);
         n++;
      end while (r !== 1'b1 && n < 20);
      if (r !== 1'b1) begin
         fails++;
         end_sim();
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
      hsel <= 1'b1;
      ahbAddr <= '{haddr: {24'h0, a}, htrans: HTRANS_NONSEQ, hwrite: wr, hsize: 3'b010};
      wait_rdy(rd);
      ahbAddr.htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      wait_rdy(rd);
      chk("hresp", hresp, HRESP_OKAY);
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
      ahb(1'b0, a, 8'h5a);
      chk(nm, rd, {24'h0, exp});
   endtask
   function automatic logic [7:0] fpa(input int i);
      return OFS_FPEN0 + 8'(4 * i);
   endfunction
   function automatic logic [7:0] sga(input int k);
      return OFS_SEG0 + 8'(4 * k);
   endfunction
   // Code bits: 0 stop3 stop, 1 wait stop, 2 in stop3, 3 in wait, 4 driver off
   function automatic logic exp_run(input int c);
      return !(c[1] && c[3]) && !(c[0] && c[2]) && c < 16;
   endfunction
   // Code bits: 0 low-power waveform, 1 irq enable, 2 frame (else sub-frame) event
   function automatic logic exp_irq(input int c);
      return c[1] && (c[2] != c[0]);
   endfunction

   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(47));
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 6; i++) begin
         rdchk("fpen_rst", fpa(i), 8'h00);
         fe[i] = 8'($urandom);
         ahb(1'b1, fpa(i), fe[i]);
      end
      ahb(1'b1, 8'hfc, 8'hff);
      rdchk("unmapped", 8'hfc, 8'h00);
      // Control read-back; ctrl0 reads back as written, unused ctrl1 and command bits must read zero
      rv = 8'($urandom);
      ahb(1'b1, OFS_CTRL0, rv);
      rdchk("ctrl0", OFS_CTRL0, rv);
      ahb(1'b1, OFS_CTRL1, 8'hff);
      rdchk("ctrl1", OFS_CTRL1, 8'h83);
      ahb(1'b1, OFS_CMD, 8'hff);
      rdchk("cmd", OFS_CMD, 8'h01);
      fe[5] &= FPEN_LAST_MASK;
      for (int i = 0; i < 6; i++) begin
         rdchk("fpen", fpa(i), fe[i]);
      end
      $display("Test registers done");
      // Enables first, then the driver, as software is advised to
      ahb(1'b1, OFS_CTRL0, 8'h80);
      for (int c = 0; c < 17; c++) begin
         ahb(1'b1, OFS_CTRL1, {6'h0, c[1:0]});
         powerMode <= c[3:2];
         if (c == 16) begin
            ahb(1'b1, OFS_CTRL0, 8'h00);
         end
         repeat (2) @(posedge clk);
         @(negedge clk);
         run = exp_run(c);
         for (int i = 0; i < 41; i++) begin
            eOn[i] = fe[i/8][i%8] & run;
         end
         chk("wave_run", waveClockRun, run);
         chk("pump_run", chargePumpRun, run);
         chk("fp_en", fpEn, eOn[40:0]);
         chk("bp_en", bpEn, {4{run}});
         @(posedge clk);
      end
      $display("Test power modes done");
      ahb(1'b1, OFS_CTRL0, 8'h80);
      powerMode <= '0;
      for (int b = 0; b < 2; b++) begin
         ahb(1'b1, OFS_CMD, 8'(b));
         for (int k = 0; k < 21; k++) begin
            blB[k] = 8'($urandom);
            ahb(1'b1, sga(k), blB[k]);
            if (b == 0) begin
               onB[k] = blB[k];
            end
         end
      end
      onB[20] &= SEG_LAST_MASK;
      blB[20] &= SEG_LAST_MASK;
      repeat (2) @(posedge clk);
      @(negedge clk);
      for (int i = 0; i < 168; i++) begin
         eOn[i] = onB[i/8][i%8];
         eBl[i] = eOn[i] & blB[i/8][i%8];
         eVis[i] = eOn[i] & fe[i/32][(i/4)%8];
      end
      chk("seg_on", segOn, eOn[163:0]);
      chk("seg_blink", segBlink, eBl[163:0]);
      chk("glass", segVis, eVis[163:0]);
      chk("glass_blink", segFl, eVis[163:0] & eBl[163:0]);
      @(posedge clk);
      for (int k = 0; k < 21; k++) begin
         rdchk("blink_rd", sga(k), blB[k]);
      end
      ahb(1'b1, OFS_CMD, 8'h00);
      for (int k = 0; k < 21; k++) begin
         rdchk("onoff_rd", sga(k), onB[k]);
      end
      $display("Test segment memory done");
      for (int c = 0; c < 8; c++) begin
         ahb(1'b1, OFS_CTRL0, {1'b1, c[0], 6'h0});
         ahb(1'b1, OFS_CTRL1, {c[1], 7'h0});
         frameEvents <= {c[2], ~c[2]};
         @(posedge clk);
         frameEvents <= '0;
         @(negedge clk);
         chk("lp_sel", lowPowerWaveSelect, c[0]);
         chk("irq", frameIrq, exp_irq(c));
         @(negedge clk);
         chk("irq_end", frameIrq, 1'b0);
         @(posedge clk);
      end
      $display("Test frame interrupt done");
      end_sim();
   end
endmodule
